// file: src/tscf_pkg.sv
// Purpose: shared constants for the thermocouple status/config/filter bank
// Assumes: register port selects registers by a small index
// Notes: all values reset to zero
package tscf_pkg;
    // register indices on the register port
    localparam logic [1:0] REG_RAW = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam logic [1:0] REG_SENSOR_CFG = 2'h2;
    // status bit positions
    localparam int ST_BURST = 7;
    localparam int ST_UPDATE = 6;
    localparam int ST_RANGE = 4;
    // sensor config fields
    localparam int CFG_TYPE_LO = 4;
    localparam int CFG_FILT_LO = 0;
    // widths and reset values
    localparam int RAW_W = 24;
    localparam int TEMP_W = 16;
    localparam int FRAC_X = 4;
    localparam int ACC_W = TEMP_W + FRAC_X;
    localparam int DIV_STEPS = 32;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    // shutdown mode field codes
    localparam logic [1:0] MODE_BURST = 2'h2;
endpackage : tscf_pkg

// file: src/tscf_bank.sv
// Purpose: raw sample, status and sensor config registers with the EMA filter
// Assumes: converter front end gives a one-cycle conv_done_i with its results
// Notes: filter divides by 2^n+1 over 32 cycles, well inside a conversion
`timescale 1ns/10ps

// Functional notes
// - read-only 24-bit raw sample, zero at reset
// - burst flag sets on burst end, software clears
// - update flag sets on each conversion
// - status bit5, config bits 7,3 read zero
// - range flag follows out-of-span indication
// - out of range freezes delta, hot, cold
// - alert bits set when source exceeds limit
// - each alert selects hot or cold source
// - config bits 6-4 select thermocouple type
// - config bits 2-0 set filter coefficient n
// - output is k*X plus (1-k)*previous output
// - hot-junction input filtered into delta register
// - config write resets filter state
// - burst takes 2^code samples then shuts down
// - low raw bits zeroed at lower resolutions
module tscf_bank (
    // clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // register port
    input wire logic [1:0] reg_sel_i,
    input wire logic wr_en_i,
    input wire logic [7:0] wr_data_i,
    output logic [23:0] rd_data_o,
    // converter results
    input wire logic conv_done_i,
    input wire logic [23:0] raw_sample_i,
    input wire logic [15:0] hot_unfilt_i,
    input wire logic [15:0] hot_comp_i,
    input wire logic [15:0] cold_i,
    input wire logic out_of_range_i,
    // device configuration and alert settings held elsewhere
    input wire logic [1:0] adc_res_i,
    input wire logic [2:0] burst_code_i,
    input wire logic [1:0] shdn_mode_i,
    input wire logic [3:0] alert_src_cold_i,
    input wire logic [15:0] alert_limit_one_i,
    input wire logic [15:0] alert_limit_two_i,
    input wire logic [15:0] alert_limit_three_i,
    input wire logic [15:0] alert_limit_four_i,
    // results
    output logic [2:0] tc_type_o,
    output logic [15:0] delta_temp_o,
    output logic [15:0] hot_temp_o,
    output logic [15:0] cold_temp_o,
    output logic burst_shutdown_o
);
    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [7:0] cfg; // sensor config
        logic [7:0] status; // status flags
        logic [23:0] raw; // raw sample
        logic [19:0] yacc; // filter output, 1/256 degree
        logic yvalid; // filter holds a previous output
        logic [15:0] hot; // compensated temperature
        logic [15:0] cold; // cold-junction temperature
        logic [15:0] delta; // filtered hot-junction temperature
        logic busy; // divider running
        logic [31:0] quo; // dividend shifting into quotient
        logic [8:0] rem; // partial remainder
        logic [7:0] den; // divisor 2^n+1
        logic neg; // result sign
        logic [5:0] step; // divider step count
        logic bactive; // burst in progress
        logic [7:0] bcnt; // samples taken in burst
        logic bmode_q; // burst mode seen last cycle
        logic shdn; // shutdown pulse
        logic [23:0] rdata; // read data
    } tscf_state_s;

    tscf_state_s s_q;
    tscf_state_s s_d;

    logic [15:0] limits [4];
    assign limits[0] = alert_limit_one_i;
    assign limits[1] = alert_limit_two_i;
    assign limits[2] = alert_limit_three_i;
    assign limits[3] = alert_limit_four_i;

    // alert comparisons, one per alert
    logic [3:0] alert_hit;
    for (genvar i = 0; i < 4; i++) begin : g_alert
        logic [15:0] src;
        assign src = alert_src_cold_i[i] ? s_q.cold : s_q.hot;
        assign alert_hit[i] = $signed(src) > $signed(limits[i]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic signed [31:0] xs;
        logic signed [31:0] ys;
        logic signed [31:0] num;
        logic [31:0] mag;
        logic [7:0] pw;
        logic [8:0] trial;
        logic [23:0] mask;
        logic [19:0] res;
        logic [7:0] stv;
        s_d = s_q;
        xs = 32'(signed'({hot_unfilt_i, 8'h00})) >>> 4;
        ys = 32'(signed'(s_q.yacc));
        pw = 8'h01 << s_q.cfg[2:0];
        num = 32'h0;
        mag = 32'h0;
        trial = 9'h0;
        res = 20'h0;
        stv = s_q.status;
        s_d.shdn = 1'b0;
        // raw sample mask per resolution
        mask = 24'hffffff << {adc_res_i, 1'b0};
        // status write: a zero in bit 7 or 6 clears it
        if (wr_en_i && reg_sel_i == tscf_pkg::REG_STATUS) begin
            s_d.status[tscf_pkg::ST_BURST] = s_q.status[tscf_pkg::ST_BURST] & wr_data_i[7];
            s_d.status[tscf_pkg::ST_UPDATE] = s_q.status[tscf_pkg::ST_UPDATE] & wr_data_i[6];
        end
        // config write: store fields, reset filter
        if (wr_en_i && reg_sel_i == tscf_pkg::REG_SENSOR_CFG) begin
            s_d.cfg = {1'b0, wr_data_i[6:4], 1'b0, wr_data_i[2:0]};
            s_d.yvalid = 1'b0;
            s_d.busy = 1'b0;
        end else if (s_q.busy) begin
            // restoring divider step
            trial = {s_q.rem[7:0], s_q.quo[31]};
            s_d.quo = {s_q.quo[30:0], 1'b0};
            if (trial >= {1'b0, s_q.den}) begin
                trial = trial - {1'b0, s_q.den};
                s_d.quo[0] = 1'b1;
            end
            s_d.rem = trial;
            s_d.step = s_q.step + 6'h01;
            if (s_q.step == 6'(tscf_pkg::DIV_STEPS - 1)) begin
                s_d.busy = 1'b0;
                res = s_d.quo[19:0];
                s_d.yacc = s_q.neg ? 20'(-res) : res;
                s_d.delta = 16'((s_d.yacc + 20'h8) >> 4);
                s_d.delta = {s_d.yacc[19], s_d.delta[14:0]};
            end
        end
        // conversion complete
        if (conv_done_i) begin
            s_d.raw = raw_sample_i & mask;
            s_d.status[tscf_pkg::ST_UPDATE] = 1'b1;
            s_d.status[tscf_pkg::ST_RANGE] = out_of_range_i;
            if (!out_of_range_i) begin
                s_d.hot = hot_comp_i;
                s_d.cold = cold_i;
                if (s_q.cfg[2:0] == 3'h0 || !s_q.yvalid) begin
                    // filter off or first sample: pass through
                    s_d.delta = hot_unfilt_i;
                    s_d.yacc = xs[19:0];
                    s_d.yvalid = 1'b1;
                    s_d.busy = 1'b0;
                end else if (!(wr_en_i && reg_sel_i == tscf_pkg::REG_SENSOR_CFG)) begin
                    // Y = (2X + (2^n-1)Y) / (2^n+1), rounded
                    num = (xs <<< 1) + ys * 32'(signed'({1'b0, pw - 8'h01}));
                    mag = num[31] ? 32'(-num) : num;
                    s_d.neg = num[31];
                    s_d.den = pw + 8'h01;
                    s_d.quo = mag + 32'(s_d.den >> 1);
                    s_d.rem = 9'h0;
                    s_d.step = 6'h0;
                    s_d.busy = 1'b1;
                end
            end
        end
        // burst sequencing
        s_d.bmode_q = (shdn_mode_i == tscf_pkg::MODE_BURST);
        if (s_d.bmode_q && !s_q.bmode_q) begin
            s_d.bactive = 1'b1;
            s_d.bcnt = 8'h0;
        end else if (s_q.bactive && conv_done_i) begin
            s_d.bcnt = s_q.bcnt + 8'h01;
            if (s_d.bcnt == (8'h01 << burst_code_i)) begin
                s_d.bactive = 1'b0;
                s_d.status[tscf_pkg::ST_BURST] = 1'b1;
                s_d.shdn = 1'b1;
            end
        end
        if (!s_d.bmode_q) begin
            s_d.bactive = 1'b0;
        end
        // alerts and reserved bit
        s_d.status[3:0] = alert_hit;
        s_d.status[5] = 1'b0;
        // registered read mux
        unique case (reg_sel_i)
            tscf_pkg::REG_RAW: s_d.rdata = s_q.raw;
            tscf_pkg::REG_STATUS: s_d.rdata = {16'h0, stv};
            tscf_pkg::REG_SENSOR_CFG: s_d.rdata = {16'h0, s_q.cfg};
            default: s_d.rdata = 24'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    assign rd_data_o = s_q.rdata;
    assign tc_type_o = s_q.cfg[6:4];
    assign delta_temp_o = s_q.delta;
    assign hot_temp_o = s_q.hot;
    assign cold_temp_o = s_q.cold;
    assign burst_shutdown_o = s_q.shdn;
endmodule : tscf_bank

// file: sim/tscf_monitor.sv
// Purpose: port checker for tscf_bank
// Assumes: read answer one cycle after select
// Notes: bound at foot of file
`timescale 1ns/10ps
module tscf_monitor (
    // clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // register port
    input wire logic [1:0] reg_sel_i,
    input wire logic wr_en_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [23:0] rd_data_o,
    // converter side
    input wire logic conv_done_i,
    input wire logic out_of_range_i,
    input wire logic [23:0] raw_sample_i,
    input wire logic [15:0] hot_comp_i,
    input wire logic [1:0] shdn_mode_i,
    // results
    input wire logic [2:0] tc_type_o,
    input wire logic [15:0] hot_temp_o,
    input wire logic [15:0] cold_temp_o,
    input wire logic burst_shutdown_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    property p_cfg; reg_sel_i == 2'h2 |=> !rd_data_o[7] && !rd_data_o[3]; endproperty
    a_cfg: assert property (p_cfg) else $error("cfg spare bit");
    property p_st5; reg_sel_i == 2'h1 |=> !rd_data_o[5]; endproperty
    a_st5: assert property (p_st5) else $error("status bit5");
    property p_raw; conv_done_i ##1 reg_sel_i == 2'h0
        |=> rd_data_o[23:8] == $past(raw_sample_i[23:8], 2); endproperty
    a_raw: assert property (p_raw) else $error("raw read");
    property p_upd; conv_done_i ##1 (reg_sel_i == 2'h1 && !wr_en_i) |=> rd_data_o[6]; endproperty
    a_upd: assert property (p_upd) else $error("update flag");
    property p_frz; conv_done_i && out_of_range_i |=> $stable(hot_temp_o) && $stable(cold_temp_o);
    endproperty
    a_frz: assert property (p_frz) else $error("held temps moved");
    property p_hot; conv_done_i && !out_of_range_i |=> hot_temp_o == $past(hot_comp_i); endproperty
    a_hot: assert property (p_hot) else $error("hot temp");
    property p_type; wr_en_i && reg_sel_i == 2'h2 |=> tc_type_o == $past(wr_data_i[6:4]); endproperty
    a_type: assert property (p_type) else $error("type field");
    property p_back; (wr_en_i && reg_sel_i == 2'h2) ##1 (reg_sel_i == 2'h2 && !wr_en_i)
        |=> rd_data_o == {16'h0000, $past(wr_data_i, 2) & 8'h77}; endproperty
    a_back: assert property (p_back) else $error("cfg readback");
    property p_burst; burst_shutdown_o
        |-> $past(conv_done_i) && $past(shdn_mode_i) == 2'h2 ##1 !burst_shutdown_o; endproperty
    a_burst: assert property (p_burst) else $error("burst end");
    c_burst: cover property (burst_shutdown_o);
    c_range: cover property (conv_done_i && out_of_range_i);
    c_cfg: cover property (wr_en_i && reg_sel_i == 2'h2);
endmodule : tscf_monitor
bind tscf_bank tscf_monitor tscf_monitor_i (.*);

// file: sim/tscf_host.sv
// Purpose: host model on the register port
// Assumes: changes at falling edge
// Notes: write data inverted once released
`timescale 1ns/10ps
module tscf_host (
    input wire logic clock_i,
    output logic [1:0] sel_o,
    output logic wen_o,
    output logic [7:0] wdat_o,
    output logic rvld_o
);
    initial {sel_o, wen_o, wdat_o, rvld_o} = 12'h000;
    // one-cycle write strobe
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        @(negedge clock_i);
        {sel_o, wen_o, wdat_o} = {s, 1'b1, d};
        @(negedge clock_i);
        {wen_o, wdat_o} = {1'b0, ~d};
    endtask : wr
    // select; answer shows one cycle later
    task automatic rd(input logic [1:0] s);
        @(negedge clock_i);
        {sel_o, rvld_o} = {s, 1'b1};
        @(negedge clock_i);
        rvld_o = 1'b0;
    endtask : rd
endmodule : tscf_host

// file: sim/tscf_bank_bench.sv
// Purpose: self-checking bench for tscf_bank
// Assumes: converter side driven at falling edge
// Notes: reads scored from a queue of notes
`timescale 1ns/10ps
module tscf_bank_bench;
    logic clock_i = 1'b0, arst_n_i = 1'b0, conv_done_i = 1'b0, out_of_range_i = 1'b0, vq = 1'b0;
    logic wr_en_i, burst_shutdown_o, rvld;
    logic [1:0] reg_sel_i, adc_res_i = 2'h0, shdn_mode_i = 2'h0;
    logic [2:0] burst_code_i = 3'h1, tc_type_o;
    logic [3:0] alert_src_cold_i = 4'h4;
    logic [7:0] wr_data_i;
    logic [23:0] rd_data_o, raw_sample_i = 24'h000000, lf = 24'h000034, exp_q[$];
    logic [15:0] hot_unfilt_i = 16'h0000, hot_comp_i = 16'h0100, cold_i = 16'h0010;
    logic [15:0] alert_limit_one_i = 16'h00ff, alert_limit_two_i = 16'h0100;
    logic [15:0] alert_limit_three_i = 16'h8000, alert_limit_four_i = 16'h7fff;
    logic [15:0] delta_temp_o, hot_temp_o, cold_temp_o;
    int n_errors = 0, checks_done = 0, n_shdn = 0;
    tscf_bank tscf_bank_i (.*);
    tscf_host tscf_host_i (.clock_i(clock_i), .sel_o(reg_sel_i), .wen_o(wr_en_i),
        .wdat_o(wr_data_i), .rvld_o(rvld));
    always #50 clock_i = ~clock_i;
    function automatic logic [23:0] nxt(input logic [23:0] v);
        return {v[22:0], v[23] ^ v[22] ^ v[21] ^ v[16]};
    endfunction : nxt
    task automatic chk(input string nm, input logic [23:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rd(input logic [1:0] s, input logic [23:0] e);
        exp_q.push_back(e);
        tscf_host_i.rd(s);
    endtask : rd
    // one conversion with a fresh random raw word
    task automatic conv(input logic [15:0] hu, input logic oor);
        @(negedge clock_i);
        lf = nxt(lf);
        {raw_sample_i, hot_unfilt_i, out_of_range_i, conv_done_i} = {lf, hu, oor, 1'b1};
        @(negedge clock_i);
        conv_done_i = 1'b0;
        repeat (40) @(negedge clock_i);
    endtask : conv
    task automatic filt(input logic [7:0] c, input logic [15:0] x1, x2, e);
        tscf_host_i.wr(2'h2, c);
        conv(x1, 1'b0);
        chk("delta first", {8'h00, delta_temp_o}, {8'h00, x1});
        conv(x2, 1'b0);
        chk("delta filt", {8'h00, delta_temp_o}, {8'h00, e});
    endtask : filt
    // answer watcher
    always @(posedge clock_i) vq <= rvld;
    always @(negedge clock_i) if (vq) chk("rd_data", rd_data_o, exp_q.pop_front());
    // burst end pulses, counted away from the launching edge
    always @(negedge clock_i) if (burst_shutdown_o) n_shdn++;
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    initial begin
        #2000000;
        n_errors++;
        close_out();
    end
    initial begin
        repeat (16) @(negedge clock_i);
        arst_n_i = 1'b1;
        // alert 3 watches cold (zero) against the most negative limit, so it is set
        for (int s = 0; s < 4; s++) rd(s[1:0], (s == 1) ? 24'h000004 : 24'h000000);
        for (int t = 0; t < 8; t++) begin
            tscf_host_i.wr(2'h2, {1'b1, t[2:0], 1'b1, t[2:0]});
            rd(2'h2, {17'h00000, t[2:0], 1'b0, t[2:0]});
            chk("tc_type", {21'h000000, tc_type_o}, {21'h000000, t[2:0]});
        end
        $display("test reset and config done");
        tscf_host_i.wr(2'h2, 8'h00);
        rd(2'h0, 24'h000000);
        conv(16'h0123, 1'b0);
        chk("delta", {8'h00, delta_temp_o}, 24'h000123);
        chk("hot", {8'h00, hot_temp_o}, 24'h000100);
        chk("cold", {8'h00, cold_temp_o}, 24'h000010);
        rd(2'h0, lf);
        rd(2'h1, 24'h000045);
        tscf_host_i.wr(2'h1, 8'h3f);
        rd(2'h1, 24'h000005);
        {adc_res_i, hot_comp_i} = {2'h3, 16'h0000};
        conv(16'h0200, 1'b1);
        hot_comp_i = 16'h0100;
        rd(2'h0, lf & 24'hffffc0);
        rd(2'h1, 24'h000055);
        chk("frozen", {8'h00, delta_temp_o}, 24'h000123);
        chk("hot frozen", {8'h00, hot_temp_o}, 24'h000100);
        $display("test convert and range done");
        filt(8'h01, 16'h0100, 16'h0400, 16'h0300);
        filt(8'h07, 16'h0100, 16'h0910, 16'h0120);
        shdn_mode_i = 2'h2;
        conv(16'h0100, 1'b0);
        chk("shdn early", 24'(n_shdn), 24'h000000);
        conv(16'h0100, 1'b0);
        chk("shdn pulses", 24'(n_shdn), 24'h000001);
        rd(2'h1, 24'h0000c5);
        $display("test filter and burst done");
        close_out();
    end
endmodule : tscf_bank_bench
